// ==== hw/pmic_watchdog_timer.sv ====
// Watchdog timer with two expiry stages behind a classic Wishbone slave
`timescale 1ns/1ps
module pmic_watchdog_timer
  import wd_pkg::*;
#(
  parameter longint BASE_TICKS = WD_BASE_CYCLES // Cycles of the shortest period
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [15:0] WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_CYC_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        HW_KICK,
  input  wire logic        SLEEP_STATE,
  output logic             ACT_IRQ,
  output logic             ACT_RESET,
  output logic             ACT_WAKE
);

  // Shortest period, sized for the counter
  localparam logic [31:0] base_ticks = 32'(BASE_TICKS);

  wd_ctrl_t    ctrl_reg;      // Control fields
  logic [15:0] key_reg;       // Last key written
  logic [31:0] count_reg;     // Cycles elapsed in the current period
  wd_stage_t   stage_reg;     // Expiry stage
  logic        hw_kick_reg;   // Previous kick input, for edge detection
  logic        ack_reg;       // Bus acknowledge
  logic [31:0] dat_reg;       // Bus read data
  wd_act_t     act_reg;       // Action strobes

  logic        bus_req;       // Request pending on the bus
  logic        wr_fire;       // Write commits at the acknowledged edge
  logic        ctrl_sel;      // Address decodes
  logic        key_sel;
  logic        status_sel;
  logic        count_sel;
  logic        unlocked;      // Key matches
  logic        sw_kick;       // Software kick write seen
  logic        hw_kick_rise;  // Hardware kick edge
  logic        kick_ok;       // Kick accepted from the selected source
  logic        run_active;    // Enabled and not stopped by sleep
  logic        counting;      // Counting this cycle
  logic [31:0] period_cycles; // Current period length
  logic        expire;        // Period ends this cycle
  wd_ctrl_t    wr_ctrl;       // Write data seen as control fields

  // Bus decode; words are word aligned so the two low address bits are ignored
  assign bus_req    = WB_CYC_I & WB_STB_I;
  assign wr_fire    = bus_req & WB_WE_I & ack_reg;
  assign ctrl_sel   = (WB_ADR_I[15:2] == WD_CTRL_ADDR[15:2]);
  assign key_sel    = (WB_ADR_I[15:2] == WD_KEY_ADDR[15:2]);
  assign status_sel = (WB_ADR_I[15:2] == WD_STATUS_ADDR[15:2]);
  assign count_sel  = (WB_ADR_I[15:2] == WD_COUNT_ADDR[15:2]);
  assign wr_ctrl    = wd_ctrl_t'(WB_DAT_I[15:0]);
  assign unlocked   = (key_reg == WD_UNLOCK_KEY);

  // Kick sources; the unselected source is simply ignored
  assign sw_kick      = wr_fire & ctrl_sel & WB_SEL_I[1] & wr_ctrl.kick_write;
  assign hw_kick_rise = HW_KICK & ~hw_kick_reg;
  assign kick_ok      = ctrl_reg.kick_source ? sw_kick : hw_kick_rise;

  // Sleep with sleep enable clear stops the timer outright
  assign run_active = ctrl_reg.run_enable & ~(SLEEP_STATE & ~ctrl_reg.sleep_enable);
  // Pause holds the count; the final stage needs no further counting
  assign counting = run_active & ~ctrl_reg.debug_pause & (stage_reg != WD_SECOND);

  // Each period code doubles the shortest period
  assign period_cycles = base_ticks << ctrl_reg.period_select;
  // Compare with >= so shrinking the period mid-count still expires at once
  assign expire = counting & (count_reg >= period_cycles - 32'h00000001);

  // Acknowledge one cycle after the request, and drop it the cycle after
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  // Read data is prepared alongside the acknowledge; unmapped reads give zero
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      dat_reg <= 32'h00000000;
    end else if (bus_req & ~ack_reg & ~WB_WE_I) begin
      if (ctrl_sel) begin
        // The kick bit is never stored, so it always reads zero
        dat_reg <= {16'h0000, ctrl_reg};
      end else if (key_sel) begin
        dat_reg <= {16'h0000, key_reg};
      end else if (status_sel) begin
        dat_reg <= {28'h0000000, stage_reg == WD_SECOND, stage_reg != WD_IDLE,
                    run_active, SLEEP_STATE};
      end else if (count_sel) begin
        dat_reg <= count_reg;
      end else begin
        dat_reg <= 32'h00000000;
      end
    end else begin
      dat_reg <= 32'h00000000;
    end
  end

  // Key register takes any value; only the magic value unlocks
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      key_reg <= WD_KEY_RESET;
    end else if (wr_fire & key_sel) begin
      if (WB_SEL_I[1]) begin
        key_reg[15:8] <= WB_DAT_I[15:8];
      end
      if (WB_SEL_I[0]) begin
        key_reg[7:0] <= WB_DAT_I[7:0];
      end
    end
  end

  // Protected fields update per byte lane only while unlocked
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_reg <= wd_ctrl_t'(WD_CTRL_RESET);
    end else if (wr_fire & ctrl_sel & unlocked) begin
      if (WB_SEL_I[1]) begin
        ctrl_reg.run_enable    <= wr_ctrl.run_enable;
        ctrl_reg.debug_pause   <= wr_ctrl.debug_pause;
        ctrl_reg.kick_source   <= wr_ctrl.kick_source;
        ctrl_reg.sleep_enable  <= wr_ctrl.sleep_enable;
        ctrl_reg.second_action <= wr_ctrl.second_action;
      end
      if (WB_SEL_I[0]) begin
        ctrl_reg.first_action  <= wr_ctrl.first_action;
        ctrl_reg.period_select <= wr_ctrl.period_select;
      end
    end
  end

  // Edge detector history for the hardware kick
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      hw_kick_reg <= 1'b0;
    end else begin
      hw_kick_reg <= HW_KICK;
    end
  end

  // Period counter; a kick wins over expiry in the same cycle
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      count_reg <= 32'h00000000;
    end else if (kick_ok) begin
      count_reg <= 32'h00000000;
    end else if (expire) begin
      count_reg <= 32'h00000000;
    end else if (counting) begin
      count_reg <= count_reg + 32'h00000001;
    end
  end

  // Stage tracking; the second stage needs two periods with no kick
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      stage_reg <= WD_IDLE;
    end else if (kick_ok) begin
      stage_reg <= WD_IDLE;
    end else if (expire) begin
      unique case (stage_reg)
        WD_IDLE:   stage_reg <= WD_FIRST;
        WD_FIRST:  stage_reg <= WD_SECOND;
        WD_SECOND: stage_reg <= WD_SECOND;
        default:   stage_reg <= WD_IDLE;
      endcase
    end
  end

  // Action strobes, one cycle at the moment a stage is entered
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      act_reg <= '0;
    end else if (expire & ~kick_ok & (stage_reg == WD_IDLE)) begin
      act_reg.irq       <= (ctrl_reg.first_action == WD_ACT_IRQ);
      act_reg.dev_reset <= (ctrl_reg.first_action == WD_ACT_RESET);
      act_reg.wake      <= (ctrl_reg.first_action == WD_ACT_WAKE);
    end else if (expire & ~kick_ok & (stage_reg == WD_FIRST)) begin
      act_reg.irq       <= (ctrl_reg.second_action == WD_ACT_IRQ);
      act_reg.dev_reset <= (ctrl_reg.second_action == WD_ACT_RESET);
      act_reg.wake      <= (ctrl_reg.second_action == WD_ACT_WAKE);
    end else begin
      act_reg <= '0;
    end
  end

  // Outputs come straight from their flip-flops
  assign WB_ACK_O  = ack_reg;
  assign WB_DAT_O  = dat_reg;
  assign ACT_IRQ   = act_reg.irq;
  assign ACT_RESET = act_reg.dev_reset;
  assign ACT_WAKE  = act_reg.wake;

  // Checks on the block's own behaviour
  a_kick_clears: assert property (@(posedge CLK) disable iff (RESET)
    kick_ok |=> (count_reg == 32'h00000000) && (stage_reg == WD_IDLE))
    else $error("accepted kick did not clear count and stage");

  a_pause_holds: assert property (@(posedge CLK) disable iff (RESET)
    (ctrl_reg.debug_pause && !kick_ok) |=> $stable(count_reg))
    else $error("count moved while paused");

  a_sleep_stops: assert property (@(posedge CLK) disable iff (RESET)
    (SLEEP_STATE && !ctrl_reg.sleep_enable && !kick_ok) |=> $stable(count_reg))
    else $error("count moved in sleep with sleep enable clear");

  a_hw_kick_gated: assert property (@(posedge CLK) disable iff (RESET)
    (!ctrl_reg.kick_source && HW_KICK && !hw_kick_reg) |=> (count_reg == 32'h00000000))
    else $error("hardware kick not honoured");

  a_sw_kick_ignored: assert property (@(posedge CLK) disable iff (RESET)
    (!ctrl_reg.kick_source && sw_kick && !hw_kick_rise && counting && !expire)
      |=> (count_reg == $past(count_reg) + 32'h00000001))
    else $error("software kick honoured with hardware source");

  a_key_locks: assert property (@(posedge CLK) disable iff (RESET)
    (wr_fire && ctrl_sel && !unlocked) |=> $stable(ctrl_reg))
    else $error("protected field changed while locked");

  a_first_action: assert property (@(posedge CLK) disable iff (RESET)
    (expire && !kick_ok && stage_reg == WD_IDLE && ctrl_reg.first_action == WD_ACT_IRQ)
      |=> ACT_IRQ && !ACT_RESET && !ACT_WAKE ##1 !ACT_IRQ)
    else $error("first stage interrupt strobe wrong");

  a_second_action: assert property (@(posedge CLK) disable iff (RESET)
    (expire && !kick_ok && stage_reg == WD_FIRST && ctrl_reg.second_action == WD_ACT_RESET)
      |=> ACT_RESET && (stage_reg == WD_SECOND))
    else $error("second stage reset strobe wrong");

  a_kick_reads_zero: assert property (@(posedge CLK) disable iff (RESET)
    (bus_req && !WB_WE_I && ctrl_sel && !ack_reg) |=> (WB_ACK_O && !WB_DAT_O[WD_KICK_BIT]))
    else $error("kick bit read back as one");

  a_ack_single: assert property (@(posedge CLK) disable iff (RESET)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge held two cycles");

  // Checks on the bus handshake and read data
  a_ack_follows_req: assert property (@(posedge CLK) disable iff (RESET)
    (bus_req && !ack_reg) |=> WB_ACK_O)
    else $error("request not acknowledged on the next cycle");

  a_ack_needs_req: assert property (@(posedge CLK) disable iff (RESET)
    !bus_req |=> !WB_ACK_O)
    else $error("acknowledge without a request");

  a_data_idle_zero: assert property (@(posedge CLK) disable iff (RESET)
    !WB_ACK_O |-> (WB_DAT_O == 32'h00000000))
    else $error("read data driven outside the acknowledge cycle");

  // Checks on counting, stages and the action strobes
  a_action_onehot: assert property (@(posedge CLK) disable iff (RESET)
    $onehot0({ACT_IRQ, ACT_RESET, ACT_WAKE}))
    else $error("more than one action strobe at once");

  a_disable_holds: assert property (@(posedge CLK) disable iff (RESET)
    (!ctrl_reg.run_enable && !kick_ok) |=> $stable(count_reg))
    else $error("count moved while disabled");

  a_count_steps: assert property (@(posedge CLK) disable iff (RESET)
    (counting && !kick_ok && !expire)
      |=> (count_reg == $past(count_reg) + 32'h00000001))
    else $error("count did not step by one");

  a_second_halts: assert property (@(posedge CLK) disable iff (RESET)
    (stage_reg == WD_SECOND && !kick_ok) |=> ($stable(count_reg) && stage_reg == WD_SECOND))
    else $error("final stage left or counted without a kick");

  a_hw_kick_ignored: assert property (@(posedge CLK) disable iff (RESET)
    (ctrl_reg.kick_source && hw_kick_rise && !sw_kick && counting && !expire)
      |=> (count_reg == $past(count_reg) + 32'h00000001))
    else $error("hardware kick honoured with software source");

  a_no_stray_action: assert property (@(posedge CLK) disable iff (RESET)
    !expire |=> (!ACT_IRQ && !ACT_RESET && !ACT_WAKE))
    else $error("action strobe without an expiry");

  a_first_entry: assert property (@(posedge CLK) disable iff (RESET)
    (expire && !kick_ok && stage_reg == WD_IDLE) |=> (stage_reg == WD_FIRST))
    else $error("first expiry did not enter the first stage");

endmodule

// ==== inc/wd_pkg.sv ====
// Shared constants and types for the watchdog timer block
package wd_pkg;

  // Register byte addresses on the Wishbone bus
  localparam logic [15:0] WD_CTRL_ADDR   = 16'h4004; // Watchdog control
  localparam logic [15:0] WD_KEY_ADDR    = 16'h4008; // Unlock key
  localparam logic [15:0] WD_STATUS_ADDR = 16'h400C; // Live status
  localparam logic [15:0] WD_COUNT_ADDR  = 16'h4010; // Live count

  // Key value that opens the protected fields
  localparam logic [15:0] WD_UNLOCK_KEY  = 16'h9716;
  localparam logic [15:0] WD_KEY_RESET   = 16'h0000;

  // Control register reset value: enabled, software kick, actions 10/01, longest period
  localparam logic [15:0] WD_CTRL_RESET  = 16'hA217;

  // Field positions inside the control word
  localparam int WD_RUN_BIT   = 15;
  localparam int WD_PAUSE_BIT = 14;
  localparam int WD_SRC_BIT   = 13;
  localparam int WD_SLP_BIT   = 12;
  localparam int WD_KICK_BIT  = 11;

  // Status bit positions
  localparam int WD_ST_SLEEP  = 0;
  localparam int WD_ST_RUN    = 1;
  localparam int WD_ST_FIRST  = 2;
  localparam int WD_ST_SECOND = 3;

  // Shortest period and the clock that counts it
  localparam longint WD_BASE_US     = 256000;     // 0.256 s
  localparam longint WD_CLK_HZ      = 50000000;   // 50 MHz
  localparam longint WD_BASE_CYCLES = (WD_BASE_US * WD_CLK_HZ) / 1000000;

  // Action codes shared by both stages
  typedef enum logic [1:0] {
    WD_ACT_NONE  = 2'b00,
    WD_ACT_IRQ   = 2'b01,
    WD_ACT_RESET = 2'b10,
    WD_ACT_WAKE  = 2'b11
  } wd_action_t;

  // Expiry stage of the timer
  typedef enum logic [1:0] {
    WD_IDLE   = 2'b00,
    WD_FIRST  = 2'b01,
    WD_SECOND = 2'b10
  } wd_stage_t;

  // Control word layout
  typedef struct packed {
    logic       run_enable;
    logic       debug_pause;
    logic       kick_source;
    logic       sleep_enable;
    logic       kick_write;
    logic       rsvd10;
    wd_action_t second_action;
    logic [1:0] rsvd7_6;
    wd_action_t first_action;
    logic       rsvd3;
    logic [2:0] period_select;
  } wd_ctrl_t;

  // One-cycle action strobes
  typedef struct packed {
    logic irq;
    logic dev_reset;
    logic wake;
  } wd_act_t;

endpackage

// ==== verif/host_kicker.sv ====
// Host model that restarts the watchdog through its hardware input
`timescale 1ns/1ps
module host_kicker (
  input  wire logic CLK,
  input  wire logic RESET,
  input  wire logic kick_go,
  output logic      HW_KICK
);
  logic [1:0] hold_reg; // Cycles left in the pulse

  // Two-cycle pulse so the rising edge is seen, then back low
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      hold_reg <= 2'h0;
    end else if (kick_go) begin
      hold_reg <= 2'h2;
    end else if (hold_reg != 2'h0) begin
      hold_reg <= hold_reg - 2'h1;
    end
  end
  assign HW_KICK = (hold_reg != 2'h0);
endmodule

// ==== verif/pmic_watchdog_timer_test.sv ====
// Self-checking bench for the watchdog timer
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module pmic_watchdog_timer_test;
  import wd_pkg::*;
  localparam int BT = 8; // Short base period keeps the run brief
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0]  sel = 4'h0;
  logic        we = 1'b0, stb = 1'b0, cyc = 1'b0, kick_go = 1'b0, sleep = 1'b0;
  logic [31:0] rdat, q, c1, c2;
  logic        ack, hw_kick, irq, dres, wake;
  int          n_mismatch = 0, check_count = 0;
  logic [3:0]  lanes = 4'hF; // Byte enables for the next bus cycle

  always #10 clk = ~clk;

  host_kicker HOST (.CLK(clk), .RESET(rst), .kick_go(kick_go), .HW_KICK(hw_kick));
  pmic_watchdog_timer #(.BASE_TICKS(BT)) DUT (.CLK(clk), .RESET(rst), .WB_ADR_I(adr),
    .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_WE_I(we), .WB_STB_I(stb), .WB_CYC_I(cyc),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .HW_KICK(hw_kick), .SLEEP_STATE(sleep),
    .ACT_IRQ(irq), .ACT_RESET(dres), .ACT_WAKE(wake));

  // Counts, verdict, end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One classic Wishbone cycle; the request holds until ack is sampled
  task automatic wb(input logic [15:0] a, input logic w, input logic [15:0] d,
                    output logic [31:0] r);
    int i;
    @(posedge clk);
    adr <= a; we <= w; wdat <= {16'h0000, d}; sel <= lanes; stb <= 1'b1; cyc <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_mismatch++;
      report_and_stop();
    end
    r = rdat;
    stb <= 1'b0; cyc <= 1'b0; we <= 1'b0;
  endtask

  // Hardware restart from the host model
  task automatic pulse();
    @(posedge clk);
    kick_go <= 1'b1;
    @(posedge clk);
    kick_go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Expected action strobe for an action code
  function automatic logic [2:0] pmap(input logic [1:0] c);
    return (c == 2'b01) ? 3'b100 : (c == 2'b10) ? 3'b010 : (c == 2'b11) ? 3'b001 : 3'b000;
  endfunction

  // Kick with given actions and period, then watch both stages fire
  task automatic run_case(input logic [1:0] f, input logic [1:0] s, input logic [2:0] ps);
    logic [2:0] p, g1, g2;
    int t1, t2, n, per;
    per = BT << ps;
    g1 = 3'b000; g2 = 3'b000; t1 = 0; t2 = 0; n = 0;
    wb(WD_CTRL_ADDR, 1'b1, 16'hA800 | {6'h00, s, 8'h00} | {10'h000, f, 4'h0} | {13'h0, ps}, q);
    for (int k = 0; k < 2 * per + 16; k++) begin
      @(posedge clk);
      p = {irq, dres, wake};
      if (p !== 3'b000) begin
        if (n == 0) begin
          g1 = p; t1 = k;
        end else begin
          g2 = p; t2 = k;
        end
        n++;
      end
    end
    if (f != 2'b00) begin
      `CHK(g1, pmap(f))
      `CHK(g2, pmap(s))
      `CHK(t2 - t1, per)
    end else begin
      `CHK(g1, pmap(s))
      `CHK(n, 1)
    end
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wb(WD_CTRL_ADDR, 1'b0, 16'h0000, q);
    `CHK(q[15:0], 16'hA217)
    wb(WD_KEY_ADDR, 1'b0, 16'h0000, q);
    `CHK(q, 32'h0000_0000)
    wb(16'h4020, 1'b1, 16'hFFFF, q);
    wb(16'h4020, 1'b0, 16'h0000, q);
    `CHK(q, 32'h0000_0000)
    wb(WD_STATUS_ADDR, 1'b0, 16'h0000, q);
    `CHK(q, 32'h0000_0002)
    wb(WD_CTRL_ADDR, 1'b1, 16'h0000, q);
    wb(WD_CTRL_ADDR, 1'b0, 16'h0000, q);
    `CHK(q[15:0], 16'hA217)
    $display("test reset_and_lock done");
    wb(WD_KEY_ADDR, 1'b1, 16'h9716, q);
    run_case(2'b01, 2'b10, 3'h0);
    run_case(2'b11, 2'b01, 3'h1);
    run_case(2'b10, 2'b11, 3'h0);
    run_case(2'b00, 2'b01, 3'h2);
    $display("test actions done");
    wb(WD_CTRL_ADDR, 1'b1, 16'hA807, q);
    wb(WD_CTRL_ADDR, 1'b0, 16'h0000, q);
    `CHK(q[15:0], 16'hA007)
    wb(WD_CTRL_ADDR, 1'b1, 16'hE007, q);
    wb(WD_COUNT_ADDR, 1'b0, 16'h0000, c1);
    repeat (20) @(posedge clk);
    wb(WD_COUNT_ADDR, 1'b0, 16'h0000, c2);
    `CHK(c2, c1)
    wb(WD_CTRL_ADDR, 1'b1, 16'h2007, q);
    wb(WD_COUNT_ADDR, 1'b0, 16'h0000, c1);
    repeat (20) @(posedge clk);
    wb(WD_COUNT_ADDR, 1'b0, 16'h0000, c2);
    `CHK(c2, c1)
    wb(WD_CTRL_ADDR, 1'b1, 16'hA007, q);
    repeat (5) @(posedge clk);
    wb(WD_COUNT_ADDR, 1'b0, 16'h0000, c2);
    `CHK(c2 > c1, 1'b1)
    $display("test pause_enable done");
    sleep <= 1'b1;
    wb(WD_STATUS_ADDR, 1'b0, 16'h0000, q);
    `CHK(q[1:0], 2'b01)
    wb(WD_COUNT_ADDR, 1'b0, 16'h0000, c1);
    repeat (10) @(posedge clk);
    wb(WD_COUNT_ADDR, 1'b0, 16'h0000, c2);
    `CHK(c2, c1)
    wb(WD_CTRL_ADDR, 1'b1, 16'hB007, q);
    wb(WD_STATUS_ADDR, 1'b0, 16'h0000, q);
    `CHK(q[1:0], 2'b11)
    sleep <= 1'b0;
    $display("test sleep done");
    pulse();
    wb(WD_COUNT_ADDR, 1'b0, 16'h0000, q);
    `CHK(q >= 32'h10, 1'b1)
    wb(WD_CTRL_ADDR, 1'b1, 16'h8007, q);
    wb(WD_CTRL_ADDR, 1'b1, 16'h8807, q);
    wb(WD_COUNT_ADDR, 1'b0, 16'h0000, q);
    `CHK(q >= 32'h10, 1'b1)
    pulse();
    wb(WD_COUNT_ADDR, 1'b0, 16'h0000, q);
    `CHK(q < 32'h10, 1'b1)
    wb(WD_CTRL_ADDR, 1'b1, 16'hA007, q);
    wb(WD_KEY_ADDR, 1'b1, 16'h0000, q);
    repeat (30) @(posedge clk);
    wb(WD_CTRL_ADDR, 1'b1, 16'h0800, q);
    wb(WD_COUNT_ADDR, 1'b0, 16'h0000, q);
    `CHK(q < 32'h10, 1'b1)
    wb(WD_CTRL_ADDR, 1'b0, 16'h0000, q);
    `CHK(q[15:0], 16'hA007)
    $display("test kick_sources done");
    wb(WD_KEY_ADDR, 1'b1, 16'h9716, q);
    wb(WD_KEY_ADDR, 1'b0, 16'h0000, q);
    `CHK(q, 32'h0000_9716)
    lanes = 4'h1;
    wb(WD_CTRL_ADDR, 1'b1, 16'h0015, q);
    lanes = 4'hF;
    wb(WD_CTRL_ADDR, 1'b0, 16'h0000, q);
    `CHK(q[15:0], 16'hA015)
    lanes = 4'h2;
    wb(WD_CTRL_ADDR, 1'b1, 16'h2000, q);
    lanes = 4'hF;
    wb(WD_CTRL_ADDR, 1'b0, 16'h0000, q);
    `CHK(q[15:0], 16'h2015)
    $display("test byte_lanes done");
    report_and_stop();
  end
endmodule
